// *** src/abx_pkg.sv ***
/*
 constants, opcodes and types for the alu and bit-operation executor.
 assumes one core clock; instruction words arrive already fetched.
*/
// Notes on behaviour
// - add literal sums accumulator and 8-bit immediate into accumulator; all flags updated.
// - add register sums accumulator and file at 7-bit address; all flags updated.
// - destination bit 0 sends result to accumulator, 1 back to the file register.
// - and register ands accumulator with file, routed by destination, only z changes.
// - and literal ands accumulator with immediate into accumulator, only z changes.
// - bit clear zeroes indexed bit of addressed file register, flags untouched.
// - bit set forces indexed bit of addressed file register to one, flags untouched.
// - skip-if-one discards next instruction with a no-op cycle when bit is one.
// - skip-if-zero discards next instruction with a no-op cycle when bit is zero.
// - read-modify-write on a port register reads pin levels, not the output latch.
package abx_pkg;
    localparam int ABX_INSN_W = 14;
    localparam int ABX_DATA_W = 8;
    localparam int ABX_ADDR_W = 7;
    // opcode prefixes
    localparam logic [5:0] ABX_OP_ADD_FILE = 6'h07;
    localparam logic [5:0] ABX_OP_AND_FILE = 6'h05;
    localparam logic [3:0] ABX_OP_BIT_CLR = 4'h4;
    localparam logic [3:0] ABX_OP_BIT_SET = 4'h5;
    localparam logic [3:0] ABX_OP_SKIP_ZERO = 4'h6;
    localparam logic [3:0] ABX_OP_SKIP_ONE = 4'h7;
    localparam logic [4:0] ABX_OP_ADD_LIT = 5'h1f;
    localparam logic [5:0] ABX_OP_AND_LIT = 6'h39;
    // field positions and reset values
    localparam int ABX_DEST_BIT = 7;
    localparam int ABX_BIT_LSB = 7;
    localparam logic [7:0] ABX_ACC_RESET = 8'h00;
    localparam logic ABX_FLAG_RESET = 1'b0;
    localparam logic [7:0] ABX_WDATA_RESET = 8'h00;
    typedef enum logic [1:0] {ABX_STATUS_C, ABX_STATUS_HC, ABX_STATUS_Z} abx_flag_e;
    typedef enum {ABX_EXEC, ABX_SKIP} abx_state_e;
endpackage : abx_pkg

// *** src/abx_alu.sv ***
/*
 8-bit adder/and unit with carry, half carry and zero.
 assumes purely combinational use by the executor.
*/
`timescale 1ns/1ps
module abx_alu (
    // operands
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic do_and_i,
    // result
    output logic [7:0] res_o,
    output logic carry_o,
    output logic half_carry_o,
    output logic zero_o
);
    import abx_pkg::*;
    wire [8:0] sum = {1'b0, a_i} + {1'b0, b_i};
    wire [4:0] low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    assign res_o = do_and_i ? (a_i & b_i) : sum[7:0];
    assign carry_o = sum[8];
    assign half_carry_o = low_sum[4];
    assign zero_o = (res_o == 8'h00);
endmodule : abx_alu

// *** src/abx_exec.sv ***
/*
 executor for add, and, bit clear/set and bit-test-skip instructions.
 assumes the caller presents one instruction per insn_valid_i pulse and
 returns the addressed file value (latch or pins) combinationally.
*/
`timescale 1ns/1ps
module abx_exec (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // instruction
    input wire logic insn_valid_i,
    input wire logic [abx_pkg::ABX_INSN_W-1:0] insn_i,
    // file register port
    output logic [abx_pkg::ABX_ADDR_W-1:0] file_addr_o,
    input wire logic [abx_pkg::ABX_DATA_W-1:0] file_latch_i,
    input wire logic [abx_pkg::ABX_DATA_W-1:0] file_pins_i,
    input wire logic file_is_port_i,
    output logic file_we_o,
    output logic [abx_pkg::ABX_DATA_W-1:0] file_wdata_o,
    // state
    output logic [abx_pkg::ABX_DATA_W-1:0] acc_o,
    output logic carry_o,
    output logic half_carry_o,
    output logic zero_o,
    output logic skip_o,
    output logic insn_done_o
);
    import abx_pkg::*;

    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic c_reg;
    logic c_next;
    logic hc_reg;
    logic hc_next;
    logic z_reg;
    logic z_next;
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    logic we_reg;
    logic we_next;
    logic done_reg;
    logic done_next;
    abx_state_e state_reg;
    abx_state_e state_next;

    // one-hot mask for a 3-bit bit index
    function automatic logic [7:0] abx_bit_mask(input logic [2:0] idx);
        abx_bit_mask = 8'h01 << idx;
    endfunction : abx_bit_mask

    // decode
    wire add_literal_to_acc = insn_i[13:9] == ABX_OP_ADD_LIT;
    wire and_literal_with_acc = insn_i[13:8] == ABX_OP_AND_LIT;
    wire add_acc_to_file = insn_i[13:8] == ABX_OP_ADD_FILE;
    wire and_acc_with_file = insn_i[13:8] == ABX_OP_AND_FILE;
    wire file_bit_clear = insn_i[13:10] == ABX_OP_BIT_CLR;
    wire file_bit_set = insn_i[13:10] == ABX_OP_BIT_SET;
    wire test_skip_if_zero = insn_i[13:10] == ABX_OP_SKIP_ZERO;
    wire test_skip_if_one = insn_i[13:10] == ABX_OP_SKIP_ONE;
    wire dest_file = insn_i[ABX_DEST_BIT];
    wire [2:0] bit_idx = insn_i[ABX_BIT_LSB +: 3];
    wire [7:0] literal = insn_i[7:0];
    wire [7:0] bit_mask = abx_bit_mask(bit_idx);
    wire take = insn_valid_i && state_reg == ABX_EXEC;

    // read value, pins for port registers
    wire [7:0] file_val = file_is_port_i ? file_pins_i : file_latch_i;
    wire is_literal = add_literal_to_acc || and_literal_with_acc;
    wire use_and = and_literal_with_acc || and_acc_with_file;
    wire [7:0] operand = is_literal ? literal : file_val;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_hc;
    wire alu_z;
    wire tested_bit = |(file_val & bit_mask);

    abx_alu u_alu (
        .a_i(acc_reg),
        .b_i(operand),
        .do_and_i(use_and),
        .res_o(alu_res),
        .carry_o(alu_c),
        .half_carry_o(alu_hc),
        .zero_o(alu_z)
    );

    always_comb begin
        acc_next = acc_reg;
        c_next = c_reg;
        hc_next = hc_reg;
        z_next = z_reg;
        wdata_next = wdata_reg;
        we_next = 1'b0;
        done_next = 1'b0;
        state_next = state_reg;
        case (state_reg)
            ABX_EXEC: begin
                if (take) begin
                    done_next = 1'b1;
                    if (add_literal_to_acc || add_acc_to_file) begin
                        c_next = alu_c;
                        hc_next = alu_hc;
                        z_next = alu_z;
                    end
                    if (use_and) begin
                        z_next = alu_z;
                    end
                    if (is_literal) begin
                        acc_next = alu_res;
                    end else if (add_acc_to_file || and_acc_with_file) begin
                        if (dest_file) begin
                            we_next = 1'b1;
                            wdata_next = alu_res;
                        end else begin
                            acc_next = alu_res;
                        end
                    end else if (file_bit_clear) begin
                        we_next = 1'b1;
                        wdata_next = file_val & ~bit_mask;
                    end else if (file_bit_set) begin
                        we_next = 1'b1;
                        wdata_next = file_val | bit_mask;
                    end else if (test_skip_if_one && tested_bit) begin
                        state_next = ABX_SKIP;
                        done_next = 1'b0;
                    end else if (test_skip_if_zero && !tested_bit) begin
                        state_next = ABX_SKIP;
                        done_next = 1'b0;
                    end
                end
            end
            ABX_SKIP: begin
                // no-op cycle; the next instruction is discarded
                if (insn_valid_i) begin
                    state_next = ABX_EXEC;
                    done_next = 1'b1;
                end
            end
            default: state_next = ABX_EXEC;
        endcase
    end

    // accumulator
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_reg <= ABX_ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // status flags
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            c_reg <= ABX_FLAG_RESET;
            hc_reg <= ABX_FLAG_RESET;
            z_reg <= ABX_FLAG_RESET;
        end else begin
            c_reg <= c_next;
            hc_reg <= hc_next;
            z_reg <= z_next;
        end
    end

    // file write data
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdata_reg <= ABX_WDATA_RESET;
        end else begin
            wdata_reg <= wdata_next;
        end
    end

    // one-cycle strobes
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            we_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            we_reg <= we_next;
            done_reg <= done_next;
        end
    end

    // execute or skip slot
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ABX_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    assign file_addr_o = insn_i[6:0];
    assign file_we_o = we_reg;
    assign file_wdata_o = wdata_reg;
    assign acc_o = acc_reg;
    assign carry_o = c_reg;
    assign half_carry_o = hc_reg;
    assign zero_o = z_reg;
    assign skip_o = state_reg == ABX_SKIP;
    assign insn_done_o = done_reg;
endmodule : abx_exec

// *** bench/abx_exec_chk.sv ***
/* port checker for abx_exec.
 bound to every abx_exec instance; sees its ports only. */
`timescale 1ns/1ps
module abx_exec_chk (
    // clock, reset, instruction
    input wire logic core_clk_i, input wire logic rst_i, input wire logic insn_valid_i,
    input wire logic [13:0] insn_i,
    // file register
    input wire logic [7:0] file_latch_i, input wire logic [7:0] file_pins_i,
    input wire logic file_is_port_i, input wire logic file_we_o,
    input wire logic [7:0] file_wdata_o,
    // state
    input wire logic [7:0] acc_o, input wire logic carry_o, input wire logic half_carry_o,
    input wire logic zero_o, input wire logic skip_o, input wire logic insn_done_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [7:0] rd = file_is_port_i ? file_pins_i : file_latch_i;
    wire logic [7:0] ob = insn_i[13] ? insn_i[7:0] : rd;
    wire logic [8:0] sm = {1'b0, acc_o} + {1'b0, ob};
    wire logic hc = ({1'b0, acc_o[3:0]} + {1'b0, ob[3:0]}) > 5'h0f;
    wire logic [7:0] mk = 8'h01 << insn_i[9:7];
    wire logic [7:0] wv = insn_i[10] ? (rd | mk) : (rd & ~mk);
    wire logic sk = insn_i[10] == |(rd & mk);
    wire logic ex = insn_valid_i && !skip_o;
    wire logic [1:0] cd = {carry_o, half_carry_o};
    wire logic [2:0] fl = {carry_o, half_carry_o, zero_o};
    chk_done_each: assert property (ex |=> insn_done_o || skip_o)
        else $error("done missing");
    chk_add_lit: assert property (ex && insn_i[13:9] == 5'h1f
        |=> {carry_o, acc_o} == $past(sm) && half_carry_o == $past(hc) && zero_o == (acc_o == 8'h00))
        else $error("add literal");
    chk_add_file: assert property (ex && insn_i[13:7] == 7'h0f
        |=> file_we_o && {carry_o, file_wdata_o} == $past(sm) && $stable(acc_o)) else $error("add file");
    chk_and_file: assert property (ex && insn_i[13:7] == 7'h0a
        |=> !file_we_o && acc_o == ($past(acc_o) & $past(rd)) && $stable(cd)) else $error("and file");
    chk_and_lit: assert property (ex && insn_i[13:8] == 6'h39
        |=> acc_o == ($past(acc_o) & $past(ob)) && zero_o == (acc_o == 8'h00) && $stable(cd))
        else $error("and literal");
    chk_bit_write: assert property (ex && insn_i[13:11] == 3'b010
        |=> file_we_o && file_wdata_o == $past(wv) && $stable(fl)) else $error("bit write");
    chk_skip_slot: assert property (ex && insn_i[13:11] == 3'b011
        |=> skip_o == $past(sk) && $stable(fl)) else $error("skip decision");
    chk_slot_void: assert property (skip_o && insn_valid_i
        |=> insn_done_o && !skip_o && !file_we_o && $stable(acc_o)) else $error("slot not void");
    cover property (ex && insn_i[13:7] == 7'h0f);
    cover property ($rose(skip_o));
    cover property (skip_o && insn_valid_i);
endmodule : abx_exec_chk
bind abx_exec abx_exec_chk u_chk (.*);

// *** bench/tb_alu_bit_ops_executor.sv ***
/* self-checking bench for abx_exec, one instruction per call.
 the bench answers file reads; pin levels are the inverse of the latch. */
`timescale 1ns/1ps
module tb_alu_bit_ops_executor;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic insn_valid_i = 1'b0;
    logic [13:0] insn_i = 14'h0000;
    logic [7:0] file_latch_i = 8'h00;
    logic [7:0] file_pins_i = 8'hff;
    logic file_is_port_i = 1'b0;
    logic [6:0] file_addr_o;
    logic [7:0] file_wdata_o, acc_o;
    logic file_we_o, carry_o, half_carry_o, zero_o, skip_o, insn_done_o;
    int miscompares = 0;
    int cmp_count = 0;
    abx_exec uut (.*);
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic ex(input logic [13:0] w, input logic [7:0] lt, input logic pt,
        input logic [21:0] e);
        logic [21:0] g;
        @(negedge core_clk_i);
        insn_i = w;
        file_latch_i = lt;
        file_pins_i = ~lt;
        file_is_port_i = pt;
        insn_valid_i = 1'b1;
        @(negedge core_clk_i);
        cmp_count++;
        if (file_addr_o !== w[6:0]) begin
            miscompares++;
            $display("[ERR] %0t address %h want %h", $time, file_addr_o, w[6:0]);
        end
        insn_valid_i = 1'b0;
        g = {file_we_o, e[20:13], acc_o, carry_o, half_carry_o, zero_o, skip_o, insn_done_o};
        if (e[21]) g[20:13] = file_wdata_o;
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : ex
    task t_file;
        ex({7'h0f, 7'h7f}, 8'hef, 1'b1, {9'h110, 8'h00, 5'b00001});
        ex({7'h0e, 7'h21}, 8'h05, 1'b0, {9'h000, 8'h05, 5'b00001});
        ex({7'h0b, 7'h22}, 8'h0a, 1'b0, {9'h100, 8'h05, 5'b00101});
        ex({7'h0a, 7'h23}, 8'hfb, 1'b1, {9'h000, 8'h04, 5'b00001});
        $display("file ops done");
    endtask : t_file
    task t_lit;
        ex({6'h3e, 8'h8c}, 8'h00, 1'b0, {9'h000, 8'h90, 5'b01001});
        ex({6'h39, 8'h10}, 8'h00, 1'b0, {9'h000, 8'h10, 5'b01001});
        ex({6'h3f, 8'hf0}, 8'h00, 1'b0, {9'h000, 8'h00, 5'b10101});
        $display("literal ops done");
    endtask : t_lit
    task t_bits;
        ex({4'h5, 3'h7, 7'h12}, 8'h01, 1'b0, {9'h181, 8'h00, 5'b10101});
        ex({4'h4, 3'h0, 7'h13}, 8'hf0, 1'b1, {9'h10e, 8'h00, 5'b10101});
        $display("bit ops done");
    endtask : t_bits
    task t_skip;
        ex({4'h7, 3'h3, 7'h14}, 8'h08, 1'b0, {9'h000, 8'h00, 5'b10110});
        ex({6'h3e, 8'h01}, 8'h00, 1'b0, {9'h000, 8'h00, 5'b10101});
        ex({4'h7, 3'h3, 7'h14}, 8'h00, 1'b0, {9'h000, 8'h00, 5'b10101});
        ex({6'h3e, 8'h01}, 8'h00, 1'b0, {9'h000, 8'h01, 5'b00001});
        ex({4'h6, 3'h0, 7'h15}, 8'h00, 1'b0, {9'h000, 8'h01, 5'b00010});
        ex({4'h5, 3'h1, 7'h15}, 8'h00, 1'b0, {9'h000, 8'h01, 5'b00001});
        ex({4'h6, 3'h0, 7'h15}, 8'hfe, 1'b1, {9'h000, 8'h01, 5'b00001});
        $display("skip ops done");
    endtask : t_skip
    initial begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        t_file;
        t_lit;
        t_bits;
        t_skip;
        give_verdict;
    end
endmodule : tb_alu_bit_ops_executor
